// ---- rtl/iap_pkg.sv ----
// constants, types and register map of the flash programming controller
package iap_pkg;
  // array geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 16;
  localparam int PAGE_WORDS = 32;
  localparam int IDX_W = 5;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BUFCLR = 8'h01;
  localparam logic [7:0] OFF_ADDR_LO = 8'h04;
  localparam logic [7:0] OFF_ADDR_HI = 8'h05;
  localparam logic [7:0] OFF_DATA_LO = 8'h06;
  localparam logic [7:0] OFF_DATA_HI = 8'h07;
  localparam logic [7:0] OFF_UNLOCK0 = 8'h08;
  localparam logic [7:0] OFF_UNLOCK5 = 8'h0D;
  // control register fields
  localparam int OP_LSB = 0;
  localparam int WINDOW_BIT = 3;
  localparam int PROG_BIT = 4;
  localparam int READ_BIT = 5;
  localparam int RDEN_BIT = 6;
  localparam int ENABLED_BIT = 7;
  localparam int BUFCLR_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // operation codes
  localparam logic [2:0] OP_WRITE = 3'h0;
  localparam logic [2:0] OP_ERASE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h3;
  localparam logic [2:0] OP_UNLOCK = 3'h6;
  // unlock key, byte k belongs to unlock register k
  localparam logic [47:0] UNLOCK_KEY = 48'h40_09_04_C3_0D_00;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 2200000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int INSTR_CLKS = 4;
  localparam int READ_INSTR = 3;
  localparam int READ_CYCLES = READ_INSTR * INSTR_CLKS;
  localparam int UNLOCK_CYCLES = 1024;
  localparam int CNT_W = 20;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ERASE = 3'b001,
    ST_WRITE = 3'b010,
    ST_HOLD  = 3'b011,
    ST_READ  = 3'b100
  } state_t;

  // command to the flash array
  typedef struct packed {
    logic erase;
    logic write;
    logic read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } flash_cmd_t;
endpackage

// ---- rtl/page_write_buffer.sv ----
// one page of write buffer held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module page_write_buffer #(
  parameter int WORDS = 32,
  parameter int WIDTH = 16,
  parameter int IDX_W = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic clear_i,
  input wire logic we_i,
  input wire logic [IDX_W-1:0] widx_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // read side
  input wire logic [IDX_W-1:0] ridx_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [WORDS];

  initial begin
    if (WORDS > (1 << IDX_W) || WORDS < 1) begin
      $error("page_write_buffer: WORDS does not fit IDX_W");
    end
  end

  // clear empties the whole page at once; clear beats a word write
  for (genvar g = 0; g < WORDS; g++) begin : g_word
    always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
        mem[g] <= '0;
      end else if (we_i && widx_i == IDX_W'(g)) begin
        mem[g] <= wdata_i;
      end
    end
  end

  assign rdata_o = mem[ridx_i];
endmodule // page_write_buffer
`default_nettype wire

// ---- rtl/inapp_flash_program_ctrl.sv ----
// in-application flash erase, write and read controller
//
// Notes on behaviour
// - operation code 001 makes the program trigger erase a page
// - operation code 000 makes the program trigger write the buffer
// - erase clears the page named by the address pair, trigger drops
// - erase always covers the whole page, never part of it
// - write keeps the program trigger high about 2.2 ms, then clears it
// - CPU is stalled while erase, write or read runs
// - buffer is committed as a whole page, indices stay in the page
// - buffer clear bit empties the buffer for a rewrite without erase
// - read needs code 011 and read enable set in the same control write as the trigger
// - read places the word in the data registers, then clears trigger
// - read completes about three instruction cycles after trigger
// - reads work without the unlock procedure
// - buffer holds one 32-word page chosen by the upper address bits
// - unlock: code 110, window bit, six key bytes before timeout
// - hardware clears the buffer clear bit when clearing is done
// - buffer index steps on each high-byte write, stops at last word
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module inapp_flash_program_ctrl #(
  parameter int PROG_CYCLES = iap_pkg::PROG_CYCLES,
  parameter int READ_CYCLES = iap_pkg::READ_CYCLES,
  parameter int UNLOCK_CYCLES = iap_pkg::UNLOCK_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // flash array
  output iap_pkg::flash_cmd_t flash_cmd_o,
  input wire logic [iap_pkg::DATA_W-1:0] flash_rdata_i,
  // processor
  output logic cpu_stall_o
);
  initial begin
    if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << iap_pkg::CNT_W) ||
        READ_CYCLES < 1 || READ_CYCLES >= (1 << iap_pkg::CNT_W) ||
        UNLOCK_CYCLES < 1 || UNLOCK_CYCLES >= (1 << iap_pkg::CNT_W)) begin
      $error("inapp_flash_program_ctrl: count out of range");
    end
  end

  localparam logic [iap_pkg::CNT_W-1:0] PROG_N =
    iap_pkg::CNT_W'(PROG_CYCLES);
  localparam logic [iap_pkg::CNT_W-1:0] READ_N =
    iap_pkg::CNT_W'(READ_CYCLES);
  localparam logic [iap_pkg::CNT_W-1:0] UNLOCK_N =
    iap_pkg::CNT_W'(UNLOCK_CYCLES);
  localparam logic [iap_pkg::IDX_W-1:0] LAST_IDX =
    iap_pkg::IDX_W'(iap_pkg::PAGE_WORDS - 1);

  // operation field of a control byte
  function automatic logic [2:0] op_of(input logic [7:0] b);
    return b[iap_pkg::OP_LSB +: 3];
  endfunction

  iap_pkg::state_t state;
  logic [iap_pkg::CNT_W-1:0] cnt;
  logic [iap_pkg::CNT_W-1:0] win_cnt;
  logic [2:0] op_select;
  logic window_on, program_trigger, read_trigger, read_enable;
  logic enabled_flag, buffer_clear;
  logic [7:0] addr_low, addr_high, data_low, data_high;
  logic [5:0] key_match;
  logic [iap_pkg::IDX_W-1:0] buf_idx;
  logic [iap_pkg::DATA_W-1:0] buf_rdata;
  logic op_done;

  wire idle = (state == iap_pkg::ST_IDLE);
  wire wr_ctrl = reg_wr_i && reg_addr_i == iap_pkg::OFF_CTRL;
  wire wr_data_hi = reg_wr_i && reg_addr_i == iap_pkg::OFF_DATA_HI;
  wire [2:0] new_op = op_of(reg_wdata_i);
  wire [iap_pkg::ADDR_W-1:0] flash_addr =
    iap_pkg::ADDR_W'({addr_high, addr_low});
  wire [iap_pkg::ADDR_W-6:0] page = flash_addr[iap_pkg::ADDR_W-1:5];
  wire unlock_wr = reg_wr_i && reg_addr_i >= iap_pkg::OFF_UNLOCK0 &&
    reg_addr_i <= iap_pkg::OFF_UNLOCK5;
  wire [2:0] key_k = 3'(reg_addr_i - iap_pkg::OFF_UNLOCK0);

  // program trigger only counts when enabled and in erase or write mode
  wire prog_go = wr_ctrl && idle && reg_wdata_i[iap_pkg::PROG_BIT] &&
    enabled_flag && (new_op == iap_pkg::OP_WRITE ||
    new_op == iap_pkg::OP_ERASE);
  // read needs the read code and read enable, but no unlock
  wire read_go = wr_ctrl && idle && reg_wdata_i[iap_pkg::READ_BIT] &&
    reg_wdata_i[iap_pkg::RDEN_BIT] &&
    new_op == iap_pkg::OP_READ;
  wire key_done = window_on && (&key_match);

  // mode bits and triggers; hardware only ever drops the triggers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_select <= iap_pkg::OP_WRITE;
      read_enable <= 1'b0;
      program_trigger <= 1'b0;
      read_trigger <= 1'b0;
    end else begin
      if (wr_ctrl && idle) begin
        op_select <= new_op;
        read_enable <= reg_wdata_i[iap_pkg::RDEN_BIT];
      end
      if (prog_go) begin
        program_trigger <= 1'b1;
      end else if (op_done) begin
        program_trigger <= 1'b0;
      end
      if (read_go) begin
        read_trigger <= 1'b1;
      end else if (op_done) begin
        read_trigger <= 1'b0;
      end
    end
  end

  // unlock window: timer runs from the window bit, key bytes checked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      window_on <= 1'b0;
      win_cnt <= '0;
      key_match <= '0;
    end else if (wr_ctrl && idle && reg_wdata_i[iap_pkg::WINDOW_BIT] &&
                 new_op == iap_pkg::OP_UNLOCK) begin
      window_on <= 1'b1;
      win_cnt <= UNLOCK_N;
      key_match <= '0;
    end else if (window_on) begin
      win_cnt <= win_cnt - 1'b1;
      if (win_cnt == 1) begin
        window_on <= 1'b0; // timeout drops it whatever was written
      end
      if (unlock_wr) begin
        key_match[key_k] <= reg_wdata_i ==
          iap_pkg::UNLOCK_KEY[8*key_k +: 8];
      end
    end
  end

  // enabled flag: set by a full key, cleared only by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enabled_flag <= 1'b0;
    end else if (key_done) begin
      enabled_flag <= 1'b1; // set wins over a same-cycle clear
    end else if (wr_ctrl && !reg_wdata_i[iap_pkg::ENABLED_BIT]) begin
      enabled_flag <= 1'b0;
    end
  end

  // buffer clear request: software sets, hardware drops after clearing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buffer_clear <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == iap_pkg::OFF_BUFCLR &&
                 reg_wdata_i[iap_pkg::BUFCLR_BIT]) begin
      buffer_clear <= 1'b1;
    end else begin
      buffer_clear <= 1'b0;
    end
  end

  // address pair and buffer index; index saturates at the last word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_low <= 8'h00;
      addr_high <= 8'h00;
      buf_idx <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == iap_pkg::OFF_ADDR_LO) begin
        addr_low <= reg_wdata_i;
        buf_idx <= reg_wdata_i[iap_pkg::IDX_W-1:0];
      end else if (wr_data_hi && buf_idx != LAST_IDX) begin
        buf_idx <= buf_idx + 1'b1;
      end
      if (reg_wr_i && reg_addr_i == iap_pkg::OFF_ADDR_HI) begin
        addr_high <= reg_wdata_i;
      end
    end
  end

  // data word registers: software writes, a finished read overwrites
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_low <= 8'h00;
      data_high <= 8'h00;
    end else if (state == iap_pkg::ST_READ && cnt == 1) begin
      // last read cycle: state is already idle once op_done shows
      {data_high, data_low} <= flash_rdata_i;
    end else begin
      if (reg_wr_i && reg_addr_i == iap_pkg::OFF_DATA_LO) begin
        data_low <= reg_wdata_i;
      end
      if (wr_data_hi) begin
        data_high <= reg_wdata_i;
      end
    end
  end

  // a word enters the buffer on its high byte, low byte taken alongside
  page_write_buffer #(
    .WORDS(iap_pkg::PAGE_WORDS),
    .WIDTH(iap_pkg::DATA_W),
    .IDX_W(iap_pkg::IDX_W)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(buffer_clear),
    .we_i(wr_data_hi && idle),
    .widx_i(buf_idx),
    .wdata_i({reg_wdata_i, data_low}),
    .ridx_i(cnt[iap_pkg::IDX_W-1:0]),
    .rdata_o(buf_rdata)
  );

  // operation sequencer; the write sweep walks the whole page
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= iap_pkg::ST_IDLE;
      cnt <= '0;
      op_done <= 1'b0;
      flash_cmd_o <= '0;
    end else begin
      op_done <= 1'b0;
      flash_cmd_o.erase <= 1'b0;
      flash_cmd_o.write <= 1'b0;
      flash_cmd_o.read <= 1'b0;
      unique case (state)
        iap_pkg::ST_IDLE: begin
          cnt <= '0;
          if (prog_go && new_op == iap_pkg::OP_ERASE) begin
            state <= iap_pkg::ST_ERASE;
          end else if (prog_go) begin
            state <= iap_pkg::ST_WRITE;
          end else if (read_go) begin
            state <= iap_pkg::ST_READ;
            flash_cmd_o.read <= 1'b1;
            flash_cmd_o.addr <= flash_addr;
            cnt <= READ_N;
          end
        end
        iap_pkg::ST_ERASE: begin
          flash_cmd_o.erase <= 1'b1;
          flash_cmd_o.addr <= {page, 5'h00};
          cnt <= PROG_N;
          state <= iap_pkg::ST_HOLD;
        end
        iap_pkg::ST_WRITE: begin
          flash_cmd_o.write <= 1'b1;
          flash_cmd_o.addr <= {page, cnt[iap_pkg::IDX_W-1:0]};
          flash_cmd_o.wdata <= buf_rdata;
          if (cnt[iap_pkg::IDX_W-1:0] == LAST_IDX) begin
            cnt <= PROG_N;
            state <= iap_pkg::ST_HOLD;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        iap_pkg::ST_HOLD: begin
          cnt <= cnt - 1'b1;
          if (cnt == 1) begin
            op_done <= 1'b1;
            state <= iap_pkg::ST_IDLE;
          end
        end
        iap_pkg::ST_READ: begin
          cnt <= cnt - 1'b1;
          if (cnt == 1) begin
            op_done <= 1'b1;
            state <= iap_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= iap_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // stall covers the whole operation, done cycle included
  assign cpu_stall_o = !idle || op_done;

  // register read, answered the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        iap_pkg::OFF_CTRL: begin
          reg_rdata_o <= {enabled_flag, read_enable, read_trigger,
            program_trigger, window_on, op_select};
        end
        iap_pkg::OFF_BUFCLR: begin
          reg_rdata_o <= {7'h00, buffer_clear};
        end
        iap_pkg::OFF_ADDR_LO: reg_rdata_o <= addr_low;
        iap_pkg::OFF_ADDR_HI: reg_rdata_o <= addr_high;
        iap_pkg::OFF_DATA_LO: reg_rdata_o <= data_low;
        iap_pkg::OFF_DATA_HI: reg_rdata_o <= data_high;
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence erase_req_s;
    prog_go && new_op == iap_pkg::OP_ERASE;
  endsequence
  sequence read_req_s;
    read_go;
  endsequence

  // age of a pending read; a stuck trigger shows up as an overage
  logic [iap_pkg::CNT_W-1:0] rd_age;
  always_ff @(posedge clk_i) begin
    rd_age <= (rst_i || !read_trigger) ? '0 : rd_age + 1'b1;
  end

  erase_mode_a: assert property (erase_req_s |-> ##2 flash_cmd_o.erase)
    else $error("erase not issued");
  write_mode_a: assert property (prog_go && new_op == iap_pkg::OP_WRITE
    |-> ##2 flash_cmd_o.write [*8])
    else $error("page write sweep not issued");
  erase_page_a: assert property (flash_cmd_o.erase
    |-> flash_cmd_o.addr[4:0] == 5'h00)
    else $error("erase not page aligned");
  trig_hold_a: assert property (erase_req_s |=> program_trigger
    throughout (state != iap_pkg::ST_IDLE)[*8])
    else $error("program trigger dropped early");
  no_unlock_a: assert property (wr_ctrl && !enabled_flag
    |=> !program_trigger)
    else $error("trigger taken while locked");
  read_ok_a: assert property (reg_wr_i && reg_addr_i == iap_pkg::OFF_CTRL
    && !reg_wdata_i[iap_pkg::RDEN_BIT] |=> !read_trigger)
    else $error("read taken without read enable");
  stall_op_a: assert property ((program_trigger || read_trigger)
    |-> cpu_stall_o)
    else $error("cpu not stalled");
  clr_drop_a: assert property (buffer_clear && !reg_wr_i
    |=> !buffer_clear)
    else $error("buffer clear bit stuck");
  idx_stop_a: assert property (wr_data_hi && buf_idx == LAST_IDX
    |=> buf_idx == LAST_IDX)
    else $error("buffer index left page");
  read_done_a: assert property (read_req_s |=> read_trigger [*2])
    else $error("read trigger not held");
  read_time_a: assert property (read_trigger |-> rd_age <= READ_N)
    else $error("read did not complete");
endmodule // inapp_flash_program_ctrl
`default_nettype wire

// ---- dv/flash_array_model.sv ----
// behavioural flash array that answers the programming controller
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  // clock
  input wire logic clk_i,
  // command from the controller
  input wire iap_pkg::flash_cmd_t cmd_i,
  // fault injection: flips bit 0 of every word written
  input wire logic corrupt_i,
  // read data to the controller
  output logic [iap_pkg::DATA_W-1:0] rdata_o
);
  logic [iap_pkg::DATA_W-1:0] mem [0:(1<<iap_pkg::ADDR_W)-1];

  // non-blank start pattern, otherwise an erase could not be seen
  initial begin
    for (int i = 0; i < (1 << iap_pkg::ADDR_W); i++) begin
      mem[i] = 16'hA500 ^ i[15:0];
    end
  end

  // erase blanks one whole page, write stores one word per pulse
  always @(posedge clk_i) begin
    if (cmd_i.erase) begin
      for (int j = 0; j < iap_pkg::PAGE_WORDS; j++) begin
        mem[{cmd_i.addr[12:5], j[4:0]}] = 16'h0000;
      end
    end
    if (cmd_i.write) begin
      mem[cmd_i.addr] = corrupt_i ? cmd_i.wdata ^ 16'h0001 : cmd_i.wdata;
    end
    // held until the next read, so the late sample still sees it
    if (cmd_i.read) begin
      rdata_o <= mem[cmd_i.addr];
    end
  end
endmodule // flash_array_model
`default_nettype wire

// ---- dv/inapp_flash_program_ctrl_bench.sv ----
// self-checking bench for the flash programming controller
`timescale 1ns/1ps
`default_nettype none
module inapp_flash_program_ctrl_bench;
  localparam int PROG = 20;
  localparam int RDC = 12;
  logic clk_i, rst_i, reg_wr_i, reg_rd_i, corrupt;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v;
  iap_pkg::flash_cmd_t flash_cmd_o;
  logic [15:0] flash_rdata_i, w;
  logic cpu_stall_o;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n;

  inapp_flash_program_ctrl #(.PROG_CYCLES(PROG), .READ_CYCLES(RDC),
    .UNLOCK_CYCLES(64)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .flash_cmd_o(flash_cmd_o),
    .flash_rdata_i(flash_rdata_i), .cpu_stall_o(cpu_stall_o));
  flash_array_model array_u (.clk_i(clk_i), .cmd_i(flash_cmd_o),
    .corrupt_i(corrupt), .rdata_o(flash_rdata_i));

  // clock generation
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask

  // bus cycles start just after an edge and return 1 ns after the next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // counts stalled cycles; bounded so a stuck stall cannot hang us
  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (cpu_stall_o === 1'b1 && cnt < 5000) begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
  endtask

  task automatic set_addr(input logic [12:0] a);
    wr(iap_pkg::OFF_ADDR_LO, a[7:0]);
    wr(iap_pkg::OFF_ADDR_HI, {3'h0, a[12:8]});
  endtask

  // read op 011 with read enable, then fetch the data pair
  task automatic fread(input logic [12:0] a, output logic [15:0] d);
    logic [7:0] lo, hi;
    int c;
    set_addr(a);
    wr(iap_pkg::OFF_CTRL, 8'hE3);
    wait_idle(c);
    rd(iap_pkg::OFF_DATA_LO, lo);
    rd(iap_pkg::OFF_DATA_HI, hi);
    d = {hi, lo};
  endtask

  task automatic fcheck(input logic [12:0] a, input logic [15:0] exp);
    fread(a, w);
    check("flash word", w, exp);
  endtask

  task automatic load(input logic [15:0] d);
    wr(iap_pkg::OFF_DATA_LO, d[7:0]);
    wr(iap_pkg::OFF_DATA_HI, d[15:8]);
  endtask

  task automatic unlock(input logic [7:0] bad);
    wr(iap_pkg::OFF_CTRL, 8'h0E);
    for (int k = 0; k < 6; k++) begin
      wr(iap_pkg::OFF_UNLOCK0 + 8'(k), iap_pkg::UNLOCK_KEY[8*k+:8] ^ bad);
    end
    @(posedge clk_i);
    #1;
    rd(iap_pkg::OFF_CTRL, v);
  endtask

  task automatic t_reset();
    rd(iap_pkg::OFF_CTRL, v);
    check("ctrl reset", 16'(v), 16'(iap_pkg::CTRL_RESET));
    rd(8'h20, v);
    check("unmapped", 16'(v), 16'h0000);
    check("stall idle", 16'(cpu_stall_o), 16'h0000);
  endtask

  // reads need op 011 plus enable, and no unlock
  task automatic t_read();
    wr(iap_pkg::OFF_CTRL, 8'h23);
    check("read no enable", 16'(cpu_stall_o), 16'h0000);
    set_addr(13'h0145);
    wr(iap_pkg::OFF_CTRL, 8'h63);
    wait_idle(n);
    check("read stall", 16'(n >= RDC && n <= RDC + 2), 16'h0001);
    rd(iap_pkg::OFF_CTRL, v);
    check("read trigger", 16'(v[iap_pkg::READ_BIT]), 16'h0000);
    fcheck(13'h0145, 16'hA500 ^ 16'h0145);
  endtask

  // erase while locked does nothing; a wrong key leaves it locked
  task automatic t_locked();
    set_addr(13'h0140);
    wr(iap_pkg::OFF_CTRL, 8'h11);
    check("locked stall", 16'(cpu_stall_o), 16'h0000);
    fcheck(13'h0140, 16'hA500 ^ 16'h0140);
    unlock(8'h01);
    check("bad key", 16'(v[iap_pkg::ENABLED_BIT]), 16'h0000);
    unlock(8'h00);
    check("good key", 16'(v[iap_pkg::ENABLED_BIT]), 16'h0001);
  endtask

  // erase from a mid-page address clears the whole page only
  task automatic t_erase();
    set_addr(13'h0145);
    wr(iap_pkg::OFF_CTRL, 8'h91);
    wait_idle(n);
    check("erase stall", 16'(n >= PROG), 16'h0001);
    rd(iap_pkg::OFF_CTRL, v);
    check("erase trigger", 16'(v[iap_pkg::PROG_BIT]), 16'h0000);
    fcheck(13'h0140, 16'h0000);
    fcheck(13'h015F, 16'h0000);
    fcheck(13'h0160, 16'hA500 ^ 16'h0160);
  endtask

  // third word lands on the last slot, index must not wrap
  task automatic t_write();
    set_addr(13'h015E);
    load(16'h1111);
    load(16'h2222);
    load(16'h3333);
    wr(iap_pkg::OFF_CTRL, 8'h90);
    wait_idle(n);
    check("write stall", 16'(n >= PROG + 32), 16'h0001);
    fcheck(13'h015E, 16'h1111);
    fcheck(13'h015F, 16'h3333);
    fcheck(13'h0160, 16'hA500 ^ 16'h0160);
  endtask

  // failed write, buffer clear, then rewrite without erase
  task automatic t_retry();
    corrupt <= 1'b1;
    set_addr(13'h0143);
    load(16'h5A5A);
    wr(iap_pkg::OFF_CTRL, 8'h90);
    wait_idle(n);
    corrupt <= 1'b0;
    fcheck(13'h0143, 16'h5A5B);
    wr(iap_pkg::OFF_BUFCLR, 8'h01);
    rd(iap_pkg::OFF_BUFCLR, v);
    check("bufclr set", 16'(v), 16'h0001);
    rd(iap_pkg::OFF_BUFCLR, v);
    check("bufclr self", 16'(v), 16'h0000);
    set_addr(13'h0143);
    load(16'h5A5A);
    wr(iap_pkg::OFF_CTRL, 8'h90);
    wait_idle(n);
    fcheck(13'h0143, 16'h5A5A);
    fcheck(13'h015E, 16'h0000);
  endtask

  // clearing the enabled flag locks erase again, reads still work
  task automatic t_disable();
    wr(iap_pkg::OFF_CTRL, 8'h00);
    rd(iap_pkg::OFF_CTRL, v);
    check("disabled", 16'(v), 16'h0000);
    set_addr(13'h0143);
    wr(iap_pkg::OFF_CTRL, 8'h11);
    check("disabled stall", 16'(cpu_stall_o), 16'h0000);
    fcheck(13'h0143, 16'h5A5A);
  endtask

  // main sequence
  initial begin
    rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    corrupt = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_read();
    t_locked();
    t_erase();
    t_write();
    t_retry();
    t_disable();
    report_and_stop();
  end
endmodule // inapp_flash_program_ctrl_bench
`default_nettype wire
